// *** laser_ctrl_pkg.sv ***
// Package for the transmit laser disable and fault control block.
// Assumes one 20 MHz clock and a synchronous active-high reset.
package laser_ctrl_pkg;

   // Diagnostic space: device address, status byte and bit positions
   localparam logic [7:0] DIAG_DEV_ADDR = 8'ha2;
   localparam logic [7:0] STATUS_BYTE_ADDR = 8'h6e;
   localparam int unsigned TX_OFF_STATE_BIT = 7;
   localparam int unsigned TX_OFF_SOFT_BIT = 6;
   localparam int unsigned TX_FAULT_BIT = 2;
   localparam int unsigned SIGNAL_LOST_BIT = 1;

   // Reset values
   localparam logic SOFT_OFF_RESET = 1'b0;
   localparam logic FAULT_LATCH_RESET = 1'b0;
   localparam logic SOFT_FAULT_EN_RESET = 1'b0;

   // Clock rate and clear-pulse filter time
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned OFF_MIN_NS = 100;
   localparam int unsigned OFF_MIN_CYC = (OFF_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam logic [3:0] OFF_MIN_CNT = 4'(OFF_MIN_CYC);

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_OFF = 2'b01,
      ST_FAULT = 2'b11,
      ST_CLEAR = 2'b10
   } tx_state_e;

   // Fault sources seen by the control logic
   typedef struct packed {
      logic laser_fault;
      logic supply_low;
      logic soft_fault;
   } fault_src_s;

   // Host view of status
   typedef struct packed {
      logic tx_off_state;
      logic tx_fault;
      logic signal_lost;
   } status_s;

endpackage

// *** pin_sync.sv ***
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes inputs are levels; only the second stage is read outside.
module pin_sync
   import laser_ctrl_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Pins
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_state_s;

   sync_state_s state_q;
   sync_state_s state_d;

   always_comb begin
      state_d = state_q;
      state_d.meta = async_in;
      state_d.sync = state_q.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign sync_out = state_q.sync;

endmodule // pin_sync

// *** laser_disable_fault_control.sv ***
// Transmit laser disable and fault control of a pluggable optical module.
// Assumes a host pull-up on the fault pin and a two-wire slave that
// decodes the diagnostic address and presents status byte accesses here.
module laser_disable_fault_control
   import laser_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Module pins
   input wire logic laser_off_pin,
   input wire logic fault_pin_in,
   output logic fault_pin_out,
   output logic fault_pin_oe,
   // Analog monitors
   input wire logic laser_fault_det,
   input wire logic supply_low_det,
   input wire logic receive_signal_lost,
   input wire logic soft_fault_det,
   // Diagnostic status byte access
   input wire logic [7:0] diag_dev_addr,
   input wire logic [7:0] diag_byte_addr,
   input wire logic diag_wr,
   input wire logic [7:0] diag_wdata,
   input wire logic soft_fault_en,
   output logic [7:0] diag_rdata,
   output logic diag_hit,
   // Laser driver
   output logic laser_enable,
   output logic tx_fault_level,
   output status_s status
);

   typedef struct packed {
      tx_state_e st;
      logic fault_latch;
      logic soft_off;
      logic soft_fault_en;
      logic [3:0] off_cnt;
      logic laser_en;
      logic fault_out;
      logic [7:0] rdata;
   } ctrl_state_s;

   ctrl_state_s state_q;
   ctrl_state_s state_d;

   // Power-up state: laser off, no fault, hardware faults only
   localparam ctrl_state_s CTRL_RESET = '{
      st: ST_OFF,
      fault_latch: FAULT_LATCH_RESET,
      soft_off: SOFT_OFF_RESET,
      soft_fault_en: SOFT_FAULT_EN_RESET,
      off_cnt: 4'h0,
      laser_en: 1'b0,
      fault_out: 1'b0,
      rdata: 8'h00
   };

   logic [3:0] pins_s;
   logic off_pin_s;
   logic laser_fault_s;
   logic supply_low_s;
   logic lost_s;
   logic off_req;
   logic status_hit;
   fault_src_s src;
   logic hw_fault;
   logic fault_now;
   logic latch_next;
   logic in_clear;
   logic off_held;
   logic clear_done;
   logic run_ok;
   logic [7:0] status_byte;

   pin_sync #(
      .WIDTH(4)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in({laser_off_pin, laser_fault_det, supply_low_det, receive_signal_lost}),
      .sync_out(pins_s)
   );

   assign off_pin_s = pins_s[3];
   assign laser_fault_s = pins_s[2];
   assign supply_low_s = pins_s[1];
   assign lost_s = pins_s[0];

   // Only the status byte address on the diagnostic device answers
   assign status_hit = (diag_dev_addr == DIAG_DEV_ADDR) && (diag_byte_addr == STATUS_BYTE_ADDR);

   assign off_req = off_pin_s | state_q.soft_off;

   always_comb begin
      src.laser_fault = laser_fault_s;
      src.supply_low = supply_low_s;
      src.soft_fault = soft_fault_det & state_q.soft_fault_en;
   end

   assign hw_fault = src.laser_fault | src.soft_fault;

   // Fault latch: a new fault wins over the clear
   assign latch_next = hw_fault | (state_q.fault_latch & !in_clear);
   assign fault_now = latch_next | src.supply_low;

   // Clear sequence helpers
   assign in_clear = (state_q.st == ST_CLEAR);
   assign off_held = (state_q.off_cnt == OFF_MIN_CNT);
   assign clear_done = off_held && !off_pin_s;

   // Laser may run only with no request and no fault of any kind
   assign run_ok = !src.supply_low && !hw_fault && !off_req;

   // Status byte image, fault bit in step with the fault pin
   always_comb begin
      status_byte = 8'h00;
      status_byte[TX_OFF_STATE_BIT] = !state_q.laser_en && off_req;
      status_byte[TX_OFF_SOFT_BIT] = state_q.soft_off;
      status_byte[TX_FAULT_BIT] = fault_now;
      status_byte[SIGNAL_LOST_BIT] = lost_s;
   end

   always_comb begin
      state_d = state_q;

      // Serial laser-off control
      if (diag_wr && status_hit) begin
         state_d.soft_off = diag_wdata[TX_OFF_SOFT_BIT];
      end
      state_d.soft_fault_en = soft_fault_en;
      state_d.fault_latch = latch_next;

      case (state_q.st)
         ST_RUN: begin
            state_d.off_cnt = '0;
            if (hw_fault) begin
               state_d.st = ST_FAULT;
            end else if (off_req) begin
               state_d.st = ST_OFF;
            end
         end

         ST_OFF: begin
            state_d.off_cnt = '0;
            if (hw_fault) begin
               state_d.st = ST_FAULT;
            end else if (!off_req) begin
               state_d.st = ST_RUN;
            end
         end

         ST_FAULT: begin
            state_d.off_cnt = '0;
            if (off_pin_s) begin
               state_d.st = ST_CLEAR;
            end
         end

         ST_CLEAR: begin
            if (!off_held) begin
               state_d.off_cnt = state_q.off_cnt + 4'h1;
            end
            if (hw_fault) begin
               state_d.st = ST_FAULT;
            end else if (clear_done) begin
               state_d.st = state_q.soft_off ? ST_OFF : ST_RUN;
            end
         end

         default: begin
            state_d.off_cnt = '0;
            state_d.st = ST_OFF;
         end
      endcase

      // Registered outputs
      state_d.laser_en = (state_d.st == ST_RUN) && run_ok;
      state_d.fault_out = fault_now;
      state_d.rdata = status_byte;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= CTRL_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // Open collector: pull low when healthy, release on fault
   assign fault_pin_out = 1'b0;
   assign fault_pin_oe = !state_q.fault_out;

   // Laser driver and status
   assign laser_enable = state_q.laser_en;
   assign tx_fault_level = state_q.fault_out;
   assign diag_hit = status_hit;
   assign diag_rdata = status_hit ? state_q.rdata : 8'h00;
   assign status = '{
      tx_off_state: state_q.rdata[TX_OFF_STATE_BIT],
      tx_fault: state_q.fault_out,
      signal_lost: state_q.rdata[SIGNAL_LOST_BIT]
   };

endmodule // laser_disable_fault_control

// *** laser_dfc_sva.sv ***
// Port checker for the laser disable and fault control block.
// Assumes binding to the top module; one clock domain.
module laser_dfc_sva
   import laser_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Pins and monitors
   input wire logic laser_off_pin,
   input wire logic laser_fault_det,
   input wire logic supply_low_det,
   input wire logic fault_pin_out,
   input wire logic fault_pin_oe,
   // Status access
   input wire logic [7:0] diag_dev_addr,
   input wire logic [7:0] diag_byte_addr,
   input wire logic diag_wr,
   input wire logic [7:0] diag_wdata,
   input wire logic [7:0] diag_rdata,
   input wire logic diag_hit,
   // Laser side
   input wire logic laser_enable,
   input wire logic tx_fault_level,
   input wire status_s status
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_pin_kills_laser: assert property (laser_off_pin [*5] |-> !laser_enable)
      else $error("laser on with off pin");
   a_fault_kills_laser: assert property (laser_fault_det [*5] |-> tx_fault_level && !laser_enable)
      else $error("laser fault not acted on");
   a_supply_fault: assert property (supply_low_det [*5] |-> tx_fault_level && !laser_enable)
      else $error("low supply not acted on");
   a_fault_dark: assert property (tx_fault_level |-> !laser_enable)
      else $error("laser on during fault");
   a_oe_mirror: assert property (fault_pin_oe != tx_fault_level)
      else $error("fault pin enable wrong");
   a_drive_zero: assert property (fault_pin_out == 1'b0)
      else $error("fault pin drives high");
   a_hit_decode: assert property (diag_hit == (diag_dev_addr == DIAG_DEV_ADDR && diag_byte_addr == STATUS_BYTE_ADDR))
      else $error("address decode wrong");
   a_miss_zero: assert property (!diag_hit |-> diag_rdata == 8'h00)
      else $error("data on miss");
   a_fault_bit: assert property (diag_hit |-> diag_rdata[TX_FAULT_BIT] == status.tx_fault)
      else $error("fault bit wrong");
   a_soft_off: assert property (diag_wr && diag_hit && diag_wdata[TX_OFF_SOFT_BIT] |-> ##[1:3] !laser_enable)
      else $error("soft off ignored");
endmodule // laser_dfc_sva

bind laser_disable_fault_control laser_dfc_sva chk (
   .ref_clk(ref_clk),
   .rst(rst),
   .laser_off_pin(laser_off_pin),
   .laser_fault_det(laser_fault_det),
   .supply_low_det(supply_low_det),
   .fault_pin_out(fault_pin_out),
   .fault_pin_oe(fault_pin_oe),
   .diag_dev_addr(diag_dev_addr),
   .diag_byte_addr(diag_byte_addr),
   .diag_wr(diag_wr),
   .diag_wdata(diag_wdata),
   .diag_rdata(diag_rdata),
   .diag_hit(diag_hit),
   .laser_enable(laser_enable),
   .tx_fault_level(tx_fault_level),
   .status(status)
);

// *** host_board.sv ***
// Host board model: laser-off request and fault line pull-up.
// Assumes tasks are called just after a clock edge.
module host_board (
   // Clock
   input wire logic ref_clk,
   // Fault line
   input wire logic fault_pin_out,
   input wire logic fault_pin_oe,
   output logic fault_pin_in,
   // Request
   output logic laser_off_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   assign fault_pin_in = fault_pin_oe ? fault_pin_out : 1'b1;
   initial laser_off_pin = 1'b0;
   task automatic toggle(input int n);
      laser_off_pin = 1'b1;
      repeat (n) @(posedge ref_clk);
      #5 laser_off_pin = 1'b0;
   endtask
endmodule // host_board

// *** tb_top.sv ***
// Self-checking bench for the laser disable and fault control block.
// Assumes host_board and laser_dfc_sva are compiled ahead.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_top import laser_ctrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst = 1, diag_wr = 0, soft_fault_en = 0, soft_fault_det = 0;
   logic laser_fault_det = 0, supply_low_det = 0, receive_signal_lost = 0;
   logic fault_pin_in, laser_off_pin, fault_pin_out, fault_pin_oe, diag_hit, laser_enable, tx_fault_level;
   logic [7:0] diag_dev_addr = 8'h00, diag_byte_addr = 8'h00, diag_wdata = 8'h00, diag_rdata;
   logic [7:0] rd_val;
   status_s status;
   int fails = 0, total_checks = 0;
   always #25 ref_clk = ~ref_clk;
   host_board hb (
      .ref_clk(ref_clk),
      .fault_pin_out(fault_pin_out),
      .fault_pin_oe(fault_pin_oe),
      .fault_pin_in(fault_pin_in),
      .laser_off_pin(laser_off_pin)
   );
   laser_disable_fault_control uut (
      .ref_clk(ref_clk),
      .rst(rst),
      .laser_off_pin(laser_off_pin),
      .fault_pin_in(fault_pin_in),
      .fault_pin_out(fault_pin_out),
      .fault_pin_oe(fault_pin_oe),
      .laser_fault_det(laser_fault_det),
      .supply_low_det(supply_low_det),
      .receive_signal_lost(receive_signal_lost),
      .soft_fault_det(soft_fault_det),
      .diag_dev_addr(diag_dev_addr),
      .diag_byte_addr(diag_byte_addr),
      .diag_wr(diag_wr),
      .diag_wdata(diag_wdata),
      .soft_fault_en(soft_fault_en),
      .diag_rdata(diag_rdata),
      .diag_hit(diag_hit),
      .laser_enable(laser_enable),
      .tx_fault_level(tx_fault_level),
      .status(status)
   );
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      diag_dev_addr = DIAG_DEV_ADDR;
      diag_byte_addr = a;
      diag_wdata = d;
      diag_wr = 1'b1;
      cyc(1);
      diag_wr = 1'b0;
   endtask
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
      diag_dev_addr = DIAG_DEV_ADDR;
      diag_byte_addr = a;
      cyc(1);
      d = diag_rdata;
   endtask
   task automatic settle(input logic en, input logic flt);
      cyc(8);
      `CHK(laser_enable, en)
      `CHK(fault_pin_in, flt)
   endtask
   task automatic conclude;
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      cyc(20);
      rst = 1'b0;
      settle(1'b1, 1'b0);
      hb.laser_off_pin = 1'b1;
      settle(1'b0, 1'b0);
      hb.laser_off_pin = 1'b0;
      settle(1'b1, 1'b0);
      wr_byte(8'h6f, 8'h40);
      settle(1'b1, 1'b0);
      `CHK({diag_hit, diag_rdata}, 9'h000)
      wr_byte(STATUS_BYTE_ADDR, 8'h40);
      settle(1'b0, 1'b0);
      `CHK(diag_rdata[7], 1'b1)
      `CHK(status, 3'b100)
      rd_byte(STATUS_BYTE_ADDR, rd_val);
      `CHK(rd_val, 8'hc0)
      hb.laser_off_pin = 1'b1;
      wr_byte(STATUS_BYTE_ADDR, 8'h00);
      settle(1'b0, 1'b0);
      hb.laser_off_pin = 1'b0;
      settle(1'b1, 1'b0);
      laser_fault_det = 1'b1;
      receive_signal_lost = 1'b1;
      settle(1'b0, 1'b1);
      `CHK(diag_rdata[2:1], 2'b11)
      `CHK(status, 3'b011)
      laser_fault_det = 1'b0;
      receive_signal_lost = 1'b0;
      settle(1'b0, 1'b1);
      hb.toggle(4);
      settle(1'b1, 1'b0);
      supply_low_det = 1'b1;
      settle(1'b0, 1'b1);
      supply_low_det = 1'b0;
      settle(1'b1, 1'b0);
      soft_fault_det = 1'b1;
      settle(1'b1, 1'b0);
      soft_fault_en = 1'b1;
      cyc(8);
      `CHK(fault_pin_in, 1'b1)
      soft_fault_det = 1'b0;
      soft_fault_en = 1'b0;
      hb.toggle(4);
      settle(1'b1, 1'b0);
      laser_fault_det = 1'b1;
      settle(1'b0, 1'b1);
      laser_fault_det = 1'b0;
      rst = 1'b1;
      cyc(20);
      `CHK(fault_pin_in, 1'b0)
      `CHK(laser_enable, 1'b0)
      rst = 1'b0;
      settle(1'b1, 1'b0);
      conclude();
   end
endmodule // tb_top
